// File: src/system_interrupt_aggregator.sv
// system interrupt aggregator: status latches, per-level enables, level encoder, dma triggers
// assumes internal event pulses on this clock, external lines asynchronous, and a one-cycle
// register port master
// Function
// - a normal event sets its status bit; writing one clears it
// - an error event sets its bit; write-one clears only written bits, events kept
// - normal status bits 30 and 31 show OR of external and error status
// - writes to the two summary bits are ignored
// - external status is read-only and follows the external request lines
// - normal enable per level forwards a pending source only when its bit is one
// - the highest enabled level wins: 6 over 4 over 2
// - gating acts on current status, so re-enabling a pending source reasserts
// - external enables per level gate external status like normal enables
// - error enables per level gate error status like normal enables
// - graphics dma start rises while any selected normal or external source is pending
// - expansion-bus dma start rises while any selected source is pending
// - the cpu request is two lines coding none, level 2, 4 or 6
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module system_interrupt_aggregator #(
  parameter int NRM_W = irq_agg_pkg::NRM_W,
  parameter int EXT_W = irq_agg_pkg::EXT_W,
  parameter int ERR_W = irq_agg_pkg::ERR_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [irq_agg_pkg::ADDR_W-1:0] address,
  input wire logic [irq_agg_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [irq_agg_pkg::DATA_W-1:0] rd_data,
  input wire logic [NRM_W-1:0] normal_irq_event,
  input wire logic [ERR_W-1:0] error_irq_event,
  input wire logic [EXT_W-1:0] external_irq_line,
  output logic [1:0] cpu_level_request_lines,
  output logic gfx_dma_start,
  output logic expbus_dma_start
);

  localparam int LEVELS = irq_agg_pkg::LEVELS;

  // external line synchroniser; first stage feeds only the status register
  logic [EXT_W-1:0] ext_meta;
  logic [EXT_W-1:0] external_irq_status;

  // status registers
  logic [NRM_W-1:0] normal_irq_status;
  logic [ERR_W-1:0] error_irq_status;
  logic [NRM_W-1:0] next_normal_irq_status;
  logic [ERR_W-1:0] next_error_irq_status;

  // per-level enables and dma trigger selects
  logic [NRM_W-1:0] nrm_enable [LEVELS];
  logic [EXT_W-1:0] ext_enable [LEVELS];
  logic [ERR_W-1:0] err_enable [LEVELS];
  logic [NRM_W-1:0] next_nrm_enable [LEVELS];
  logic [EXT_W-1:0] next_ext_enable [LEVELS];
  logic [ERR_W-1:0] next_err_enable [LEVELS];
  logic [NRM_W-1:0] gfx_dma_trigger_normal;
  logic [EXT_W-1:0] gfx_dma_trigger_external;
  logic [NRM_W-1:0] expbus_dma_trigger_normal;
  logic [EXT_W-1:0] expbus_dma_trigger_external;
  logic [NRM_W-1:0] next_gfx_trig_nrm;
  logic [EXT_W-1:0] next_gfx_trig_ext;
  logic [NRM_W-1:0] next_exp_trig_nrm;
  logic [EXT_W-1:0] next_exp_trig_ext;

  // outputs
  logic [irq_agg_pkg::DATA_W-1:0] next_rd_data;
  logic [1:0] next_level;
  logic next_gfx_start;
  logic next_exp_start;

  logic [LEVELS-1:0] level_hit;
  logic gfx_hit;
  logic exp_hit;
  logic wr_nrm;
  logic wr_err;

  assign wr_nrm = wr_strobe && (address == irq_agg_pkg::OFS_NRM_STATUS);
  assign wr_err = wr_strobe && (address == irq_agg_pkg::OFS_ERR_STATUS);

  // external lines: two flops, then the read-only status view
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ext_meta <= '0;
      external_irq_status <= '0;
    end
    else
    begin
      ext_meta <= external_irq_line;
      external_irq_status <= ext_meta;
    end
  end

  // status update; a set in the clearing cycle wins over the clear
  always_comb
  begin
    next_normal_irq_status = normal_irq_status;
    next_error_irq_status = error_irq_status;
    if (wr_nrm)
    begin
      // bits 30 and 31 are not stored, so writes there do nothing
      next_normal_irq_status = normal_irq_status & ~wr_data[NRM_W-1:0];
    end
    if (wr_err)
    begin
      next_error_irq_status = error_irq_status & ~wr_data[ERR_W-1:0];
    end
    next_normal_irq_status = next_normal_irq_status | normal_irq_event;
    next_error_irq_status = next_error_irq_status | error_irq_event;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      normal_irq_status <= '0;
      error_irq_status <= '0;
    end
    else
    begin
      normal_irq_status <= next_normal_irq_status;
      error_irq_status <= next_error_irq_status;
    end
  end

  // enable and trigger-select registers
  always_comb
  begin
    next_nrm_enable = nrm_enable;
    next_ext_enable = ext_enable;
    next_err_enable = err_enable;
    next_gfx_trig_nrm = gfx_dma_trigger_normal;
    next_gfx_trig_ext = gfx_dma_trigger_external;
    next_exp_trig_nrm = expbus_dma_trigger_normal;
    next_exp_trig_ext = expbus_dma_trigger_external;
    if (wr_strobe)
    begin
      for (int l = 0; l < LEVELS; l++)
      begin
        if (address == irq_agg_pkg::OFS_NRM_ENABLE[l])
        begin
          next_nrm_enable[l] = wr_data[NRM_W-1:0];
        end
        if (address == irq_agg_pkg::OFS_EXT_ENABLE[l])
        begin
          next_ext_enable[l] = wr_data[EXT_W-1:0];
        end
        if (address == irq_agg_pkg::OFS_ERR_ENABLE[l])
        begin
          next_err_enable[l] = wr_data[ERR_W-1:0];
        end
      end
      if (address == irq_agg_pkg::OFS_GFX_TRIG_NRM)
      begin
        next_gfx_trig_nrm = wr_data[NRM_W-1:0];
      end
      if (address == irq_agg_pkg::OFS_GFX_TRIG_EXT)
      begin
        next_gfx_trig_ext = wr_data[EXT_W-1:0];
      end
      if (address == irq_agg_pkg::OFS_EXP_TRIG_NRM)
      begin
        next_exp_trig_nrm = wr_data[NRM_W-1:0];
      end
      if (address == irq_agg_pkg::OFS_EXP_TRIG_EXT)
      begin
        next_exp_trig_ext = wr_data[EXT_W-1:0];
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int l = 0; l < LEVELS; l++)
      begin
        nrm_enable[l] <= '0;
        ext_enable[l] <= '0;
        err_enable[l] <= '0;
      end
      gfx_dma_trigger_normal <= '0;
      gfx_dma_trigger_external <= '0;
      expbus_dma_trigger_normal <= '0;
      expbus_dma_trigger_external <= '0;
    end
    else
    begin
      nrm_enable <= next_nrm_enable;
      ext_enable <= next_ext_enable;
      err_enable <= next_err_enable;
      gfx_dma_trigger_normal <= next_gfx_trig_nrm;
      gfx_dma_trigger_external <= next_gfx_trig_ext;
      expbus_dma_trigger_normal <= next_exp_trig_nrm;
      expbus_dma_trigger_external <= next_exp_trig_ext;
    end
  end

  // one gate per level
  generate
    for (genvar g = 0; g < LEVELS; g++)
    begin : gen_level
      level_gate #(
        .NRM_W(NRM_W),
        .EXT_W(EXT_W),
        .ERR_W(ERR_W)
      ) u_gate (
        .nrm_status(normal_irq_status),
        .nrm_enable(nrm_enable[g]),
        .ext_status(external_irq_status),
        .ext_enable(ext_enable[g]),
        .err_status(error_irq_status),
        .err_enable(err_enable[g]),
        .hit(level_hit[g])
      );
    end
  endgenerate

  // dma triggers have no error group
  level_gate #(
    .NRM_W(NRM_W),
    .EXT_W(EXT_W),
    .ERR_W(ERR_W)
  ) u_gfx_gate (
    .nrm_status(normal_irq_status),
    .nrm_enable(gfx_dma_trigger_normal),
    .ext_status(external_irq_status),
    .ext_enable(gfx_dma_trigger_external),
    .err_status(error_irq_status),
    .err_enable({ERR_W{1'b0}}),
    .hit(gfx_hit)
  );

  level_gate #(
    .NRM_W(NRM_W),
    .EXT_W(EXT_W),
    .ERR_W(ERR_W)
  ) u_exp_gate (
    .nrm_status(normal_irq_status),
    .nrm_enable(expbus_dma_trigger_normal),
    .ext_status(external_irq_status),
    .ext_enable(expbus_dma_trigger_external),
    .err_status(error_irq_status),
    .err_enable({ERR_W{1'b0}}),
    .hit(exp_hit)
  );

  // level encoder, dma starts and read data
  always_comb
  begin
    if (level_hit[irq_agg_pkg::IDX_L6])
    begin
      next_level = irq_agg_pkg::LVL_6;
    end
    else if (level_hit[irq_agg_pkg::IDX_L4])
    begin
      next_level = irq_agg_pkg::LVL_4;
    end
    else if (level_hit[irq_agg_pkg::IDX_L2])
    begin
      next_level = irq_agg_pkg::LVL_2;
    end
    else
    begin
      next_level = irq_agg_pkg::LVL_NONE;
    end
    next_gfx_start = gfx_hit;
    next_exp_start = exp_hit;
    next_rd_data = '0;
    // unmapped addresses read as zero; the read has no side effect
    if (rd_strobe)
    begin
      case (address)
        irq_agg_pkg::OFS_NRM_STATUS:
        begin
          next_rd_data[NRM_W-1:0] = normal_irq_status;
          next_rd_data[irq_agg_pkg::SUM_EXT_BIT] = |external_irq_status;
          next_rd_data[irq_agg_pkg::SUM_ERR_BIT] = |error_irq_status;
        end
        irq_agg_pkg::OFS_EXT_STATUS: next_rd_data[EXT_W-1:0] = external_irq_status;
        irq_agg_pkg::OFS_ERR_STATUS: next_rd_data[ERR_W-1:0] = error_irq_status;
        irq_agg_pkg::OFS_GFX_TRIG_NRM: next_rd_data[NRM_W-1:0] = gfx_dma_trigger_normal;
        irq_agg_pkg::OFS_GFX_TRIG_EXT: next_rd_data[EXT_W-1:0] = gfx_dma_trigger_external;
        irq_agg_pkg::OFS_EXP_TRIG_NRM: next_rd_data[NRM_W-1:0] = expbus_dma_trigger_normal;
        irq_agg_pkg::OFS_EXP_TRIG_EXT: next_rd_data[EXT_W-1:0] = expbus_dma_trigger_external;
        default:
        begin
          for (int l = 0; l < LEVELS; l++)
          begin
            if (address == irq_agg_pkg::OFS_NRM_ENABLE[l])
            begin
              next_rd_data[NRM_W-1:0] = nrm_enable[l];
            end
            if (address == irq_agg_pkg::OFS_EXT_ENABLE[l])
            begin
              next_rd_data[EXT_W-1:0] = ext_enable[l];
            end
            if (address == irq_agg_pkg::OFS_ERR_ENABLE[l])
            begin
              next_rd_data[ERR_W-1:0] = err_enable[l];
            end
          end
        end
      endcase
    end
  end

  // registered outputs cost one cycle of request latency but keep the cpu pins glitch free
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cpu_level_request_lines <= irq_agg_pkg::LVL_NONE;
      gfx_dma_start <= 1'b0;
      expbus_dma_start <= 1'b0;
      rd_data <= '0;
    end
    else
    begin
      cpu_level_request_lines <= next_level;
      gfx_dma_start <= next_gfx_start;
      expbus_dma_start <= next_exp_start;
      rd_data <= next_rd_data;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  AST_NRM_SET: assert property (
    (|normal_irq_event) |=> ((normal_irq_status & $past(normal_irq_event)) ==
                             $past(normal_irq_event)))
    else $error("normal event did not set its status bit");

  AST_NRM_CLR: assert property (
    (wr_nrm && ((wr_data[NRM_W-1:0] & normal_irq_event) == '0))
    |=> ((normal_irq_status & $past(wr_data[NRM_W-1:0])) == '0))
    else $error("write one did not clear normal status");

  AST_ERR_KEEP: assert property (
    wr_err |=> (error_irq_status == (($past(error_irq_status) & ~$past(wr_data)) |
                                    $past(error_irq_event))))
    else $error("error clear touched unwritten bits or lost an event");

  AST_SUMMARY: assert property (
    (rd_strobe && address == irq_agg_pkg::OFS_NRM_STATUS)
    |=> (rd_data[irq_agg_pkg::SUM_ERR_BIT] == $past(|error_irq_status)) &&
        (rd_data[irq_agg_pkg::SUM_EXT_BIT] == $past(|external_irq_status)))
    else $error("summary bits do not match external and error status");

  AST_EXT_FOLLOW: assert property (
    (external_irq_line == $past(external_irq_line, 1)) &&
    (external_irq_line == $past(external_irq_line, 2)) |-> ##1
    (external_irq_status == $past(external_irq_line, 1)))
    else $error("external status does not follow the stable line");

  AST_LEVEL6: assert property (
    level_hit[irq_agg_pkg::IDX_L6] |=> (cpu_level_request_lines == irq_agg_pkg::LVL_6))
    else $error("level 6 not presented while enabled and pending");

  AST_LEVEL2: assert property (
    (level_hit == 3'h1) |=> (cpu_level_request_lines == irq_agg_pkg::LVL_2))
    else $error("level 2 alone not presented");

  AST_REASSERT: assert property (
    ((wr_strobe && wr_data[0] && address == irq_agg_pkg::OFS_NRM_ENABLE[irq_agg_pkg::IDX_L6])
     ##1 normal_irq_status[0])
    |-> ##1 (cpu_level_request_lines == irq_agg_pkg::LVL_6))
    else $error("re-enabled pending source did not reassert level 6");

  AST_NONE: assert property (
    (level_hit == '0) |=> (cpu_level_request_lines == irq_agg_pkg::LVL_NONE))
    else $error("request stays up with nothing enabled and pending");

  AST_DMA: assert property (
    gfx_hit |=> gfx_dma_start ##0 (expbus_dma_start == $past(exp_hit)))
    else $error("dma start does not follow selected pending sources");

endmodule : system_interrupt_aggregator
`default_nettype wire

// File: src/irq_agg_pkg.sv
// constants for the system interrupt aggregator: widths, register byte addresses, level codes
// assumes a 32-bit register port that presents full byte addresses
package irq_agg_pkg;

  localparam int NRM_W = 22;
  localparam int EXT_W = 4;
  localparam int ERR_W = 32;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;
  localparam int LEVELS = 3;

  // summary bits of the normal status word
  localparam int SUM_EXT_BIT = 30;
  localparam int SUM_ERR_BIT = 31;

  // index of each level in the per-level arrays
  localparam int IDX_L2 = 0;
  localparam int IDX_L4 = 1;
  localparam int IDX_L6 = 2;

  // level request encoding on the two cpu lines
  localparam logic [1:0] LVL_NONE = 2'h0;
  localparam logic [1:0] LVL_2 = 2'h1;
  localparam logic [1:0] LVL_4 = 2'h2;
  localparam logic [1:0] LVL_6 = 2'h3;

  localparam logic [ADDR_W-1:0] OFS_NRM_STATUS = 32'h005F6900;
  localparam logic [ADDR_W-1:0] OFS_EXT_STATUS = 32'h005F6904;
  localparam logic [ADDR_W-1:0] OFS_ERR_STATUS = 32'h005F6908;
  localparam logic [ADDR_W-1:0] OFS_NRM_ENABLE [LEVELS] = '{32'h005F6910, 32'h005F6920,
                                                           32'h005F6930};
  localparam logic [ADDR_W-1:0] OFS_EXT_ENABLE [LEVELS] = '{32'h005F6914, 32'h005F6924,
                                                           32'h005F6934};
  localparam logic [ADDR_W-1:0] OFS_ERR_ENABLE [LEVELS] = '{32'h005F6918, 32'h005F6928,
                                                           32'h005F6938};
  localparam logic [ADDR_W-1:0] OFS_GFX_TRIG_NRM = 32'h005F6940;
  localparam logic [ADDR_W-1:0] OFS_GFX_TRIG_EXT = 32'h005F6944;
  localparam logic [ADDR_W-1:0] OFS_EXP_TRIG_NRM = 32'h005F6950;
  localparam logic [ADDR_W-1:0] OFS_EXP_TRIG_EXT = 32'h005F6954;

endpackage : irq_agg_pkg

// File: src/level_gate.sv
// one enable gate: status bits of the three source groups against one set of enables
// assumes status and enables come from registers on the same clock
`timescale 1ns/1ps
`default_nettype none
module level_gate #(
  parameter int NRM_W = irq_agg_pkg::NRM_W,
  parameter int EXT_W = irq_agg_pkg::EXT_W,
  parameter int ERR_W = irq_agg_pkg::ERR_W
) (
  input wire logic [NRM_W-1:0] nrm_status,
  input wire logic [NRM_W-1:0] nrm_enable,
  input wire logic [EXT_W-1:0] ext_status,
  input wire logic [EXT_W-1:0] ext_enable,
  input wire logic [ERR_W-1:0] err_status,
  input wire logic [ERR_W-1:0] err_enable,
  output logic hit
);

  // level sensitive on purpose: re-enabling a pending source raises the hit again
  always_comb
  begin
    hit = (|(nrm_status & nrm_enable)) | (|(ext_status & ext_enable)) |
          (|(err_status & err_enable));
  end

endmodule : level_gate
`default_nettype wire

// File: verification/host_cpu_model.sv
// host cpu model: owns the register port and blocks itself around interrupt register changes
// assumes the aggregator answers a read one cycle after the strobe and never stalls
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
  input wire logic clock,
  input wire logic [1:0] cpu_level_request_lines,
  input wire logic [31:0] rd_data,
  output logic [31:0] address,
  output logic [31:0] wr_data,
  output logic wr_strobe,
  output logic rd_strobe
);
  logic blocked;
  logic [1:0] taken_level;
  initial
  begin
    address = 32'h0;
    wr_data = 32'h0;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    blocked = 1'b0;
    taken_level = 2'h0;
  end
  // a blocked cpu takes no request, so a cancel cannot race its acknowledge
  always @(posedge clock)
    if (!blocked && cpu_level_request_lines != 2'h0)
      taken_level <= cpu_level_request_lines;
  task automatic write_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clock);
    wr_strobe <= 1'b0;
    wr_data <= ~d;
  endtask : write_reg
  task automatic read_reg(input logic [31:0] a, output logic [31:0] d);
    @(posedge clock);
    address <= a;
    rd_strobe <= 1'b1;
    @(posedge clock);
    rd_strobe <= 1'b0;
    @(posedge clock);
    d = rd_data;
  endtask : read_reg
  // two dummy reads give the change time to reach the cpu input before unblocking
  task automatic guarded_write(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    blocked = 1'b1;
    write_reg(a, d);
    read_reg(a, dummy);
    read_reg(a, dummy);
    blocked = 1'b0;
  endtask : guarded_write
  // inside a handler the cancel sets the block bit itself, then writes and reads twice like guarded_write
  task automatic handler_cancel(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    blocked = 1'b1;
    write_reg(a, d);
    read_reg(a, dummy);
    read_reg(a, dummy);
    blocked = 1'b0;
  endtask : handler_cancel
  task automatic block_cpu();
    blocked = 1'b1;
  endtask : block_cpu
  task automatic confirm_cleared(input logic [31:0] a, output logic [31:0] d);
    logic [31:0] dummy;
    read_reg(a, d);
    read_reg(a, dummy);
    read_reg(a, dummy);
    blocked = 1'b0;
  endtask : confirm_cleared
endmodule : host_cpu_model
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench for the interrupt aggregator: random and directed register traffic
// assumes the host model drives the register port and the bench drives all sources
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock;
  logic rst;
  logic [31:0] address, wr_data, rd_data;
  logic wr_strobe, rd_strobe, gfx_dma_start, expbus_dma_start;
  logic [irq_agg_pkg::NRM_W-1:0] normal_irq_event;
  logic [irq_agg_pkg::ERR_W-1:0] error_irq_event;
  logic [irq_agg_pkg::EXT_W-1:0] external_irq_line;
  logic [1:0] cpu_level_request_lines;
  int failures, checked;
  logic [31:0] en [13];
  logic [31:0] nrm, ext, err, v;
  logic [31:0] trig_ofs [4] = '{irq_agg_pkg::OFS_GFX_TRIG_NRM, irq_agg_pkg::OFS_GFX_TRIG_EXT,
    irq_agg_pkg::OFS_EXP_TRIG_NRM, irq_agg_pkg::OFS_EXP_TRIG_EXT};
  int step_i [11] = '{0, 4, 8, 8, 8, 8, 2, 2, 2, 9, 12};
  logic [31:0] step_d [11] = '{32'h1, 32'h2, 32'h10, 32'h0, 32'h10, 32'h0, 32'h1, 32'h0,
    32'h1, 32'h1, 32'h2};
  system_interrupt_aggregator system_interrupt_aggregator_i (.clock(clock), .rst(rst),
    .address(address), .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .rd_data(rd_data), .normal_irq_event(normal_irq_event), .error_irq_event(error_irq_event),
    .external_irq_line(external_irq_line), .cpu_level_request_lines(cpu_level_request_lines),
    .gfx_dma_start(gfx_dma_start), .expbus_dma_start(expbus_dma_start));
  host_cpu_model host_cpu_model_i (.clock(clock),
    .cpu_level_request_lines(cpu_level_request_lines), .rd_data(rd_data), .address(address),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe));
  function automatic logic [31:0] wmask(input int i);
    if (i < 3 || i == 9 || i == 11)
      return (32'h1 << irq_agg_pkg::NRM_W) - 32'h1;
    if (i < 6 || i == 10 || i == 12)
      return (32'h1 << irq_agg_pkg::EXT_W) - 32'h1;
    return 32'hFFFFFFFF;
  endfunction : wmask
  function automatic logic [31:0] rw_addr(input int i);
    if (i < 3)
      return irq_agg_pkg::OFS_NRM_ENABLE[i];
    if (i < 6)
      return irq_agg_pkg::OFS_EXT_ENABLE[i-3];
    if (i < 9)
      return irq_agg_pkg::OFS_ERR_ENABLE[i-6];
    return trig_ofs[i-9];
  endfunction : rw_addr
  // ascending scan, so the last enabled level found is the highest
  function automatic logic [1:0] exp_level();
    logic [1:0] code [3];
    logic [1:0] r;
    code = '{irq_agg_pkg::LVL_2, irq_agg_pkg::LVL_4, irq_agg_pkg::LVL_6};
    r = irq_agg_pkg::LVL_NONE;
    for (int l = 0; l < 3; l++)
      if (((en[l] & nrm) | (en[l+3] & ext) | (en[l+6] & err)) != 32'h0)
        r = code[l];
    return r;
  endfunction : exp_level
  function automatic logic [31:0] nrm_word();
    return {(err != 32'h0), (ext != 32'h0), 30'h0} | nrm;
  endfunction : nrm_word
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
    host_cpu_model_i.read_reg(a, v);
    check(name, v, exp);
  endtask : rd_chk
  task automatic chk_out();
    logic [31:0] lv, el;
    logic gx, xx;
    repeat (4) @(posedge clock);
    #1;
    lv = {30'h0, cpu_level_request_lines};
    el = {30'h0, exp_level()};
    gx = |((en[9] & nrm) | (en[10] & ext));
    xx = |((en[11] & nrm) | (en[12] & ext));
    check("level", lv, el);
    check("gfx_dma", {31'h0, gfx_dma_start}, {31'h0, gx});
    check("expbus_dma", {31'h0, expbus_dma_start}, {31'h0, xx});
  endtask : chk_out
  task automatic set_en(input int i, input logic [31:0] d);
    en[i] = d & wmask(i);
    host_cpu_model_i.guarded_write(rw_addr(i), d);
  endtask : set_en
  task automatic pulse(input logic [31:0] n, input logic [31:0] e);
    @(posedge clock);
    normal_irq_event <= n[irq_agg_pkg::NRM_W-1:0];
    error_irq_event <= e;
    @(posedge clock);
    normal_irq_event <= '0;
    error_irq_event <= '0;
    nrm |= n & wmask(0);
    err |= e;
  endtask : pulse
  task automatic set_ext(input logic [31:0] x);
    @(posedge clock);
    external_irq_line <= x[irq_agg_pkg::EXT_W-1:0];
    ext = x & wmask(3);
    repeat (6) @(posedge clock);
  endtask : set_ext
  task automatic clr_nrm(input logic [31:0] d);
    nrm &= ~(d & wmask(0));
    host_cpu_model_i.handler_cancel(irq_agg_pkg::OFS_NRM_STATUS, d);
  endtask : clr_nrm
  task automatic clr_err(input logic [31:0] d);
    err &= ~d;
    host_cpu_model_i.handler_cancel(irq_agg_pkg::OFS_ERR_STATUS, d);
  endtask : clr_err
  task automatic close_out();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // generous bound: the sequence needs well under two thousand cycles
  initial
  begin
    repeat (30000) @(posedge clock);
    failures++;
    close_out();
  end
  initial
  begin
    rst = 1'b1;
    normal_irq_event = '0;
    error_irq_event = '0;
    external_irq_line = '0;
    failures = 0;
    checked = 0;
    nrm = 32'h0;
    ext = 32'h0;
    err = 32'h0;
    foreach (en[i]) en[i] = 32'h0;
    v = $urandom(32'hEE6A);
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 13; i++)
      rd_chk("reset_value", rw_addr(i), 32'h0);
    rd_chk("nrm_reset", irq_agg_pkg::OFS_NRM_STATUS, 32'h0);
    rd_chk("unmapped", 32'h005F690C, 32'h0);
    for (int i = 0; i < 13; i++)
    begin
      set_en(i, $urandom);
      rd_chk("enable_rw", rw_addr(i), en[i]);
    end
    chk_out();
    pulse($urandom | 32'h1, 32'h0);
    rd_chk("nrm_set", irq_agg_pkg::OFS_NRM_STATUS, nrm_word());
    clr_nrm($urandom | 32'hC0000000);
    pulse(32'h0, 32'h00009000);
    rd_chk("err_summary", irq_agg_pkg::OFS_NRM_STATUS, nrm_word());
    pulse(32'h0, 32'h00000010);
    clr_err(32'h00008000);
    rd_chk("err_w1c", irq_agg_pkg::OFS_ERR_STATUS, err);
    set_ext(32'h5);
    rd_chk("ext_status", irq_agg_pkg::OFS_EXT_STATUS, 32'h5);
    rd_chk("ext_summary", irq_agg_pkg::OFS_NRM_STATUS, nrm_word());
    host_cpu_model_i.write_reg(irq_agg_pkg::OFS_EXT_STATUS, 32'hF);
    rd_chk("ext_readonly", irq_agg_pkg::OFS_EXT_STATUS, 32'h5);
    chk_out();
    host_cpu_model_i.block_cpu();
    set_ext(32'h0);
    host_cpu_model_i.confirm_cleared(irq_agg_pkg::OFS_EXT_STATUS, v);
    check("ext_cancel", v, 32'h0);
    for (int i = 0; i < 13; i++)
      set_en(i, 32'h0);
    pulse(32'h1, 32'h10);
    set_ext(32'h2);
    // a trigger alone moves no data; only the start level is observed
    for (int s = 0; s < 11; s++)
    begin
      set_en(step_i[s], step_d[s]);
      chk_out();
    end
    check("cpu_taken", {30'h0, host_cpu_model_i.taken_level}, {30'h0, exp_level()});
    for (int k = 0; k < 40; k++)
    begin
      case ($urandom_range(4, 0))
        0: pulse($urandom, $urandom & 32'h000F00FF);
        1: set_en($urandom_range(12, 0), $urandom);
        2: clr_nrm($urandom);
        3: set_ext($urandom);
        default: clr_err($urandom);
      endcase
      chk_out();
      rd_chk("nrm_random", irq_agg_pkg::OFS_NRM_STATUS, nrm_word());
      rd_chk("err_random", irq_agg_pkg::OFS_ERR_STATUS, err);
    end
    close_out();
  end
endmodule : testbench
`default_nettype wire
